// *** logic/esr_ctrl_regs.vh ***
// Register offsets, fields, opcodes and timing counts of the erase suspend/resume controller
`ifndef ESR_CTRL_REGS_VH
`define ESR_CTRL_REGS_VH
// APB register byte offsets
`define ESR_OFF_CMD      12'h000
`define ESR_OFF_ADDR     12'h004
`define ESR_OFF_STAT1    12'h008
`define ESR_OFF_STAT2    12'h00C
`define ESR_OFF_INFO     12'h010
`define ESR_OFF_BANK     12'h014
`define ESR_OFF_ENGINE   12'h018
// Status field positions
`define ESR_S1_BUSY      0
`define ESR_S1_WEL       1
`define ESR_S1_PERR      6
`define ESR_S2_PSUS      0
`define ESR_S2_ESUS      1
// INFO register fields
`define ESR_I_ACCEPT     0
`define ESR_I_REFUSE     1
`define ESR_I_BULK       2
`define ESR_I_ESUSPEND   3
`define ESR_I_PSUSPEND   4
`define ESR_I_BADREAD    5
// ENGINE register fields (completion strobes from the self-timed engine)
`define ESR_E_ERASEDONE  0
`define ESR_E_PROGDONE   1
// Sector size: 256 kbyte sectors
`define ESR_SECT_LSB     18
// Opcodes
`define ESR_OP_CFG_WR    8'h01
`define ESR_OP_PG_WR     8'h02
`define ESR_OP_READ      8'h03
`define ESR_OP_STAT1_RD  8'h05
`define ESR_OP_UNLOCK    8'h06
`define ESR_OP_STAT2_RD  8'h07
`define ESR_OP_PG_WR4    8'h12
`define ESR_OP_BANK_RD   8'h16
`define ESR_OP_BANK_WR   8'h17
`define ESR_OP_CLR_STAT  8'h30
`define ESR_OP_QPG_WR    8'h32
`define ESR_OP_QPG_WR4   8'h34
`define ESR_OP_CFG_RD    8'h35
`define ESR_OP_QPG_WRB   8'h38
`define ESR_OP_BE        8'h60
`define ESR_OP_ESUSP     8'h75
`define ESR_OP_ERES      8'h7A
`define ESR_OP_PSUSP     8'h85
`define ESR_OP_PRES      8'h8A
`define ESR_OP_BANK_ACC  8'hB9
`define ESR_OP_BEB       8'hC7
`define ESR_OP_SE        8'hD8
`define ESR_OP_SE4       8'hDC
`define ESR_OP_VLOCK_RD  8'hE0
`define ESR_OP_VLOCK_WR  8'hE1
`define ESR_OP_PLOCK_RD  8'hE2
`define ESR_OP_PLOCK_ERS 8'hE4
`define ESR_OP_RESET     8'hF0
`define ESR_OP_MODE_CLR  8'hFF
// Default erase halt latency in bus clock cycles
`define ESR_HALT_LAT_CYC 16'h15F9
`endif

// *** logic/esr_ctrl.v ***
// Erase suspend/resume command gate and status tracker with an APB slave
//
// Contract
// - Erase halt accepted only during sector erase
// - Erase halt ignored during bulk erase
// - Suspend completes within bounded latency
// - Only status reads while suspend settles
// - Busy bit clears when erase stops
// - Erase-suspended flag tells suspended versus finished
// - Erase continue ignored unless erase suspended
// - Reads in suspended sector flagged undefined
// - Config write, persistent erase refused in suspend
// - Write after bank access goes bank register
// - Program in suspended sector fails, error
// - Program done returns to erase suspend
// - Erase continue sets busy, repeats ignored
// - All array reads accepted in suspend
// - Bank read and write accepted in idle and suspend; only bank read while erase or program runs
// - Page writes only in erase suspend
// - Volatile lock commands only in erase suspend
// - Clear status, persistent read erase-suspend only
// - Nested program halt; program continue both
// - Mode bit clear accepted in suspend
// - Program-suspended flag tells suspended versus finished
`timescale 1ns/1ns
`default_nettype none
`include "esr_ctrl_regs.vh"

module esr_ctrl
#(
  parameter [15:0] SUSP_LAT_CYC = `ESR_HALT_LAT_CYC
)
(
  // Clock and reset
  input  wire        sys_clk,
  input  wire        nrst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Engine status outputs
  output reg         eraseRun,
  output reg         progRun,
  output reg         bankWrite
);

  // ==========================================================
  // States
  // ==========================================================
  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_SERS  = 3'd1; // sector erase running
  localparam [2:0] ST_BERS  = 3'd2; // bulk erase running
  localparam [2:0] ST_EWAIT = 3'd3; // erase suspend settling
  localparam [2:0] ST_ESUS  = 3'd4; // erase suspended
  localparam [2:0] ST_PROG  = 3'd5; // program running (maybe nested)
  localparam [2:0] ST_PWAIT = 3'd6; // program suspend settling
  localparam [2:0] ST_PSUS  = 3'd7; // program suspended

  reg [2:0]  state_r;
  reg        nested_r;     // program lives inside an erase suspend
  reg [31:0] addr_r;       // command address written by software
  reg [31:0] suspAddr_r;   // sector under erase
  reg [31:0] progAddr_r;
  reg [15:0] latCnt_r;
  reg        busy_r;
  reg        wel_r;
  reg        perr_r;
  reg        eSus_r;
  reg        pSus_r;
  reg        bankAccPend_r;
  reg [7:0]  bank_r;
  reg [7:0]  cfg_r;
  reg        accept_r;
  reg        refuse_r;
  reg        badRead_r;

  // ==========================================================
  // APB decode
  // ==========================================================
  wire apbWr    = psel & penable & pwrite;
  wire apbRd    = psel & penable & ~pwrite;
  wire mapped   = (paddr == `ESR_OFF_CMD) | (paddr == `ESR_OFF_ADDR) |
                  (paddr == `ESR_OFF_STAT1) | (paddr == `ESR_OFF_STAT2) |
                  (paddr == `ESR_OFF_INFO) | (paddr == `ESR_OFF_BANK) |
                  (paddr == `ESR_OFF_ENGINE);
  wire cmdStb   = apbWr & (paddr == `ESR_OFF_CMD) & ~pready;
  wire engStb   = apbWr & (paddr == `ESR_OFF_ENGINE) & ~pready;
  wire [7:0] op = pwdata[7:0];
  wire eraseDone = engStb & pwdata[`ESR_E_ERASEDONE];
  wire progDone  = engStb & pwdata[`ESR_E_PROGDONE];

  // Array reads of every width and data rate, plain and four-byte address
  wire isRead  = (op == `ESR_OP_READ) |
                 (op == 8'h13) |
                 (op == 8'h0B) |
                 (op == 8'h0C) |
                 (op == 8'h0D) |
                 (op == 8'h0E) |
                 (op == 8'h3B) |
                 (op == 8'h3C) |
                 (op == 8'h6B) |
                 (op == 8'h6C) |
                 (op == 8'hBB) |
                 (op == 8'hBC) |
                 (op == 8'hBD) |
                 (op == 8'hBE) |
                 (op == 8'hEB) |
                 (op == 8'hEC) |
                 (op == 8'hED) |
                 (op == 8'hEE);

  // Page writes, single and quad input
  wire isProg  = (op == `ESR_OP_PG_WR) |
                 (op == `ESR_OP_PG_WR4) |
                 (op == `ESR_OP_QPG_WR) |
                 (op == `ESR_OP_QPG_WRB) |
                 (op == `ESR_OP_QPG_WR4);

  // Status reads, the only commands while a halt settles
  wire isStat  = (op == `ESR_OP_STAT1_RD) |
                 (op == `ESR_OP_STAT2_RD);

  // Command address falls in the halted sector
  wire sameSec = (addr_r[31:`ESR_SECT_LSB] == suspAddr_r[31:`ESR_SECT_LSB]);

  // Allowed in both suspend kinds
  wire okBoth  = isRead |
                 isStat |
                 (op == `ESR_OP_BANK_ACC) |
                 (op == `ESR_OP_BANK_RD) |
                 (op == `ESR_OP_BANK_WR) |
                 (op == `ESR_OP_MODE_CLR) |
                 (op == `ESR_OP_PRES) |
                 (op == `ESR_OP_CFG_RD) |
                 (op == `ESR_OP_RESET) |
                 ((op == `ESR_OP_CFG_WR) & bankAccPend_r);
  // Extra commands allowed during erase suspend but not during program suspend
  wire okErs   = isProg |
                 (op == `ESR_OP_UNLOCK) |
                 (op == `ESR_OP_CLR_STAT) |
                 (op == `ESR_OP_VLOCK_RD) |
                 (op == `ESR_OP_VLOCK_WR) |
                 (op == `ESR_OP_PLOCK_RD) |
                 (op == `ESR_OP_PSUSP) |
                 (op == `ESR_OP_ERES);

  reg allowed;
  // Command allow-list per state
  always @*
  begin
    case (state_r)
      ST_EWAIT, ST_PWAIT: allowed = isStat;
      ST_ESUS:            allowed = okBoth | okErs;
      ST_PSUS:            allowed = okBoth;
      ST_IDLE:            allowed = 1'b1;
      default:            allowed = isStat | isRead | (op == `ESR_OP_ESUSP) |
                                    (op == `ESR_OP_PSUSP) | (op == `ESR_OP_BANK_RD);
    endcase
  end

  // ==========================================================
  // Main control
  // ==========================================================
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r    <= ST_IDLE;
      nested_r   <= 1'b0;
      addr_r     <= 32'h00000000;
      suspAddr_r <= 32'h00000000;
      progAddr_r <= 32'h00000000;
      latCnt_r   <= 16'h0000;
      busy_r     <= 1'b0;
      wel_r      <= 1'b0;
      perr_r     <= 1'b0;
      eSus_r     <= 1'b0;
      pSus_r     <= 1'b0;
      bankAccPend_r <= 1'b0;
      bank_r     <= 8'h00;
      cfg_r      <= 8'h00;
      accept_r   <= 1'b0;
      refuse_r   <= 1'b0;
      badRead_r  <= 1'b0;
      eraseRun   <= 1'b0;
      progRun    <= 1'b0;
      bankWrite  <= 1'b0;
    end
    else
    begin
      bankWrite <= 1'b0;
      // Command address latch
      if (apbWr & ~pready & (paddr == `ESR_OFF_ADDR))
        addr_r <= pwdata;
      // Suspend latency countdown
      if (state_r == ST_EWAIT || state_r == ST_PWAIT)
      begin
        if (latCnt_r != 16'h0000)
          latCnt_r <= latCnt_r - 16'h0001;
        else if (state_r == ST_EWAIT)
        begin
          state_r <= ST_ESUS;
          busy_r  <= 1'b0;
          eSus_r  <= 1'b1;
          eraseRun <= 1'b0;
        end
        else
        begin
          state_r <= ST_PSUS;
          busy_r  <= 1'b0;
          pSus_r  <= 1'b1;
          progRun <= 1'b0;
        end
      end
      // Engine completion: finished before suspend took effect leaves flag clear
      if (eraseDone & (state_r == ST_SERS || state_r == ST_BERS || state_r == ST_EWAIT))
      begin
        state_r  <= ST_IDLE;
        busy_r   <= 1'b0;
        eSus_r   <= 1'b0;
        wel_r    <= 1'b0;
        eraseRun <= 1'b0;
      end
      if (progDone & (state_r == ST_PROG || state_r == ST_PWAIT))
      begin
        state_r <= nested_r ? ST_ESUS : ST_IDLE;
        nested_r <= 1'b0;
        busy_r  <= 1'b0;
        pSus_r  <= 1'b0;
        wel_r   <= 1'b0;
        progRun <= 1'b0;
      end
      // Command decode
      if (cmdStb)
      begin
        accept_r <= allowed;
        refuse_r <= ~allowed;
        if (allowed)
        begin
          // Any other accepted command ends a pending bank access
          if (op != `ESR_OP_BANK_ACC)
            bankAccPend_r <= 1'b0;
          // Reads in the halted sector return undefined data
          if (isRead)
            badRead_r <= (state_r == ST_ESUS) & sameSec;
          case (op)
            `ESR_OP_UNLOCK:   wel_r <= 1'b1;
            `ESR_OP_BANK_ACC: bankAccPend_r <= 1'b1;
            `ESR_OP_BANK_WR:
            begin
              bank_r    <= pwdata[15:8];
              bankWrite <= 1'b1;
            end
            `ESR_OP_CFG_WR:
            begin
              // Right after a bank access the write lands in the bank register
              if (bankAccPend_r)
              begin
                bank_r    <= pwdata[15:8];
                bankWrite <= 1'b1;
              end
              else if (wel_r)
                cfg_r <= pwdata[15:8];
            end
            `ESR_OP_CLR_STAT: perr_r <= 1'b0;
            `ESR_OP_SE, `ESR_OP_SE4:
              if (wel_r & (state_r == ST_IDLE))
              begin
                state_r    <= ST_SERS;
                suspAddr_r <= addr_r;
                busy_r     <= 1'b1;
                eraseRun   <= 1'b1;
              end
            `ESR_OP_BE, `ESR_OP_BEB:
              if (wel_r & (state_r == ST_IDLE))
              begin
                state_r  <= ST_BERS;
                busy_r   <= 1'b1;
                eraseRun <= 1'b1;
              end
            `ESR_OP_ESUSP:
              if (state_r == ST_SERS)
              begin
                state_r  <= ST_EWAIT;
                latCnt_r <= SUSP_LAT_CYC;
              end
            `ESR_OP_ERES:
              if (state_r == ST_ESUS)
              begin
                state_r  <= ST_SERS;
                busy_r   <= 1'b1;
                eSus_r   <= 1'b0;
                eraseRun <= 1'b1;
              end
            `ESR_OP_PSUSP:
              if (state_r == ST_PROG)
              begin
                state_r  <= ST_PWAIT;
                latCnt_r <= SUSP_LAT_CYC;
              end
            `ESR_OP_PRES:
              if (state_r == ST_PSUS)
              begin
                state_r <= ST_PROG;
                busy_r  <= 1'b1;
                pSus_r  <= 1'b0;
                progRun <= 1'b1;
              end
            default:
              if (isProg & wel_r & (state_r == ST_IDLE || state_r == ST_ESUS))
              begin
                if ((state_r == ST_ESUS) & sameSec)
                begin
                  perr_r <= 1'b1;
                  wel_r  <= 1'b0;
                end
                else
                begin
                  state_r    <= ST_PROG;
                  nested_r   <= (state_r == ST_ESUS);
                  progAddr_r <= addr_r;
                  busy_r     <= 1'b1;
                  progRun    <= 1'b1;
                end
              end
          endcase
        end
      end
    end
  end

  // ==========================================================
  // APB answer: one wait state per access phase, read data registered
  // ==========================================================
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      // Each access phase is answered once, one cycle after it is taken
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (apbRd & ~pready)
      begin
        case (paddr)
          `ESR_OFF_ADDR:  prdata <= addr_r;
          `ESR_OFF_STAT1: prdata <= {25'h0000000, perr_r, 4'h0, wel_r, busy_r};
          `ESR_OFF_STAT2: prdata <= {30'h00000000, eSus_r, pSus_r};
          `ESR_OFF_INFO:  prdata <= {26'h0000000, badRead_r, state_r == ST_PSUS,
                                     state_r == ST_ESUS, state_r == ST_BERS,
                                     refuse_r, accept_r};
          `ESR_OFF_BANK:  prdata <= {16'h0000, cfg_r, bank_r};
          default:        prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// *** test/esr_ctrl_chk.sv ***
// Assertion checker for the erase suspend/resume controller ports
`timescale 1ns/1ns
`default_nettype none
`include "esr_ctrl_regs.vh"
// ==========================================
// Checker
module esr_ctrl_chk
#(
  parameter [15:0] SUSP_LAT_CYC = 16'h0004
)
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        nrst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Engine
  input wire logic        eraseRun,
  input wire logic        progRun,
  input wire logic        bankWrite
);
  localparam int LATMAX = SUSP_LAT_CYC + 3;
  logic [15:0] haltCnt_r;
  logic        secErase_r;
  logic        susp_r;
  logic        pHalt_r;
  logic        bank_access_cmd_r;
  wire logic       act   = psel && penable && pwrite && !pready;
  wire logic       cmdWr = act && paddr == `ESR_OFF_CMD;
  wire logic       engWr = act && paddr == `ESR_OFF_ENGINE;
  wire logic [7:0] op    = pwdata[7:0];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Track halt latency, erase kind, suspension and bank access
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
    begin
      haltCnt_r  <= 16'h0000;
      secErase_r <= 1'b0;
      susp_r     <= 1'b0;
      pHalt_r    <= 1'b0;
      bank_access_cmd_r     <= 1'b0;
    end
    else
    begin
      if ((engWr && pwdata[0]) || (!eraseRun && haltCnt_r != 0))
        haltCnt_r <= 16'h0000;
      else if (haltCnt_r != 0)
        haltCnt_r <= haltCnt_r + 16'h0001;
      else if (cmdWr && op == 8'h75 && eraseRun && secErase_r)
        haltCnt_r <= 16'h0001;
      if (cmdWr && (op == 8'hD8 || op == 8'hDC))
        secErase_r <= 1'b1;
      else if (cmdWr && (op == 8'h60 || op == 8'hC7))
        secErase_r <= 1'b0;
      if (haltCnt_r != 0 && !eraseRun && !(engWr && pwdata[0]))
        susp_r <= 1'b1;
      else if ((cmdWr && op == 8'h7A && !pHalt_r && !progRun) || (engWr && pwdata[0]))
        susp_r <= 1'b0;
      if (cmdWr && op == 8'h85 && progRun)
        pHalt_r <= 1'b1;
      else if ((cmdWr && op == 8'h8A) || (engWr && pwdata[1]))
        pHalt_r <= 1'b0;
      if (cmdWr)
        bank_access_cmd_r <= (op == 8'hB9);
    end
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready not one cycle after access");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_halt_bounded: assert property (haltCnt_r <= LATMAX)
    else $error("erase halt latency exceeded");
  a_bulk_keeps_run: assert property (cmdWr && op == 8'h75 && eraseRun && !secErase_r |=> eraseRun [*2])
    else $error("bulk erase disturbed by halt");
  a_resume_restarts: assert property (cmdWr && op == 8'h7A && susp_r && !pHalt_r && !progRun |-> ##[1:2] eraseRun)
    else $error("erase continue did not restart erase");
  a_resume_noop: assert property (cmdWr && op == 8'h7A && !eraseRun && !(susp_r && !pHalt_r && !progRun) |=> !eraseRun [*2])
    else $error("erase continue acted with no erase halted");
  a_settle_no_prog: assert property (cmdWr && haltCnt_r != 0 && op == 8'h02 |=> !progRun [*2])
    else $error("program accepted while halt settles");
  a_bank_after_access: assert property (cmdWr && op == 8'h01 && bank_access_cmd_r && susp_r |-> ##[1:2] bankWrite)
    else $error("write after bank access missed bank register");
  a_bank_pulse: assert property (bankWrite |=> !bankWrite)
    else $error("bank write pulse too long");
  c_sector_halt: cover property (cmdWr && op == 8'h75 && eraseRun && secErase_r);
  c_bank_in_susp: cover property (susp_r && bankWrite);
  c_unmapped: cover property (pslverr);
endmodule
bind esr_ctrl esr_ctrl_chk #(.SUSP_LAT_CYC(SUSP_LAT_CYC)) chk (.sys_clk(sys_clk), .nrst(nrst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .eraseRun(eraseRun),
  .progRun(progRun), .bankWrite(bankWrite));
`default_nettype wire

// *** test/esr_host_model.sv ***
// APB host model that issues flash controller commands
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Host
module esr_host_model
(
  // Clock
  input  wire logic        sys_clk,
  // APB request
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  // APB answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Idle bus at time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end
  // One transfer; request held until pready, then released with scrambled lines
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1)
      @(posedge sys_clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// *** test/tb_erase_suspend_resume_ctrl.sv ***
// Self-checking bench for the erase suspend/resume controller
`timescale 1ns/1ns
`default_nettype none
`include "esr_ctrl_regs.vh"
// ==========================================
// Bench
module tb_erase_suspend_resume_ctrl;
  logic        sys_clk, nrst, psel, penable, pwrite, pready, pslverr, e;
  logic        eraseRun, progRun, bankWrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v, secA, secB, d;
  int          n_fail, num_checks, mS1, mS2;
  logic [7:0]  esOps[$] = '{8'h03, 8'h0B, 8'h0D, 8'hED, 8'h16, 8'hE0, 8'hE1, 8'h30,
                            8'hE2, 8'h35, 8'hFF, 8'h05, 8'h07};
  logic [7:0]  psOff[$] = '{8'h02, 8'hE0, 8'hE2, 8'h30, 8'h7A};
  esr_ctrl #(.SUSP_LAT_CYC(16'h0004)) dut (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .eraseRun(eraseRun), .progRun(progRun),
    .bankWrite(bankWrite));
  esr_host_model host (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // Clock at 125 MHz
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    num_checks++;
    if (got !== ex)
    begin
      $display("BAD %s expected %h seen %h", nm, ex, got);
      n_fail++;
    end
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] dt = 8'h00);
    host.xfer(1'b1, `ESR_OFF_CMD, {16'h0000, dt, op}, v, e);
  endtask
  task automatic wreg(input logic [11:0] a, input logic [31:0] dt);
    host.xfer(1'b1, a, dt, v, e);
  endtask
  task automatic rdr(input logic [11:0] a);
    host.xfer(1'b0, a, 32'h00000000, v, e);
  endtask
  // Compare status bits with the model
  task automatic stat;
    rdr(`ESR_OFF_STAT1);
    chk("busy and error", mS1, v & 32'h00000041);
    rdr(`ESR_OFF_STAT2);
    chk("suspend flags", mS2, v & 32'h00000003);
  endtask
  // Issue a command and check whether it was taken
  task automatic info(input logic [7:0] op, input int ok);
    cmd(op);
    rdr(`ESR_OFF_INFO);
    chk("accept or refuse", ok ? 1 : 2, v & 32'h00000003);
  endtask
  // Poll busy until it drops, bounded
  task automatic settle;
    int k;
    k = 0;
    do
    begin
      rdr(`ESR_OFF_STAT1);
      k++;
    end
    while (v[0] !== 1'b0 && k < 40);
  endtask
  // Watchdog
  initial
  begin
    #(8 * 20000);
    n_fail++;
    test_done;
  end
  // Main sequence
  initial
  begin
    n_fail = 0;
    num_checks = 0;
    nrst = 1'b0;
    void'($urandom(32'hE1A4));
    secA = $urandom & 32'hFFFC0000;
    secB = secA ^ 32'h00040000;
    mS1 = 0;
    mS2 = 0;
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    rdr(12'h0FC);
    chk("unmapped error", 1, e);
    chk("unmapped data", 0, v);
    stat;
    // Bulk erase keeps running through a halt; write unlock first
    cmd(8'h06);
    cmd(8'h60);
    mS1 = 1;
    cmd(8'h75);
    repeat (8) @(posedge sys_clk);
    stat;
    wreg(`ESR_OFF_ENGINE, 32'h00000001);
    mS1 = 0;
    stat;
    info(8'h75, 1);
    stat;
    // Sector erase, halt, program refused while settling
    wreg(`ESR_OFF_ADDR, secA);
    cmd(8'h06);
    cmd(8'hD8);
    mS1 = 1;
    stat;
    chk("erase run", 1, eraseRun);
    cmd(8'h75);
    info(8'h02, 0);
    settle;
    mS1 = 0;
    mS2 = 2;
    stat;
    foreach (esOps[i]) info(esOps[i], 1);
    cmd(8'h06);
    info(8'h01, 0);
    cmd(8'h06);
    info(8'hE4, 0);
    wreg(`ESR_OFF_ADDR, secA + 32'h4);
    cmd(8'h03);
    rdr(`ESR_OFF_INFO);
    chk("read in halted sector", 1, v[5]);
    wreg(`ESR_OFF_ADDR, secB);
    cmd(8'h03);
    rdr(`ESR_OFF_INFO);
    chk("read elsewhere", 0, v[5]);
    // Bank register write after bank access
    d = $urandom & 32'h000000FF;
    cmd(8'hB9);
    cmd(8'h01, d[7:0]);
    rdr(`ESR_OFF_BANK);
    chk("bank register", d, v & 32'h000000FF);
    // Program into the halted sector fails
    wreg(`ESR_OFF_ADDR, secA);
    cmd(8'h06);
    cmd(8'h02);
    mS1 = 32'h40;
    stat;
    cmd(8'h30);
    mS1 = 0;
    stat;
    // Nested program, halted and continued
    wreg(`ESR_OFF_ADDR, secB);
    cmd(8'h06);
    cmd(8'h02);
    mS1 = 1;
    stat;
    chk("program run", 1, progRun);
    cmd(8'h85);
    settle;
    mS1 = 0;
    mS2 = 3;
    stat;
    foreach (psOff[i]) info(psOff[i], 0);
    info(8'h8A, 1);
    mS1 = 1;
    mS2 = 2;
    stat;
    wreg(`ESR_OFF_ENGINE, 32'h00000002);
    mS1 = 0;
    stat;
    rdr(`ESR_OFF_INFO);
    chk("back in erase halt", 1, v[3]);
    // Continue, repeated continue, continue after completion
    info(8'h7A, 1);
    mS1 = 1;
    mS2 = 0;
    stat;
    info(8'h7A, 0);
    repeat (8) @(posedge sys_clk);
    wreg(`ESR_OFF_ENGINE, 32'h00000001);
    mS1 = 0;
    info(8'h7A, 1);
    stat;
    chk("erase run", 0, eraseRun);
    // Erase finishing while the halt settles leaves no suspension behind
    cmd(8'h06);
    cmd(8'hD8);
    cmd(8'h75);
    wreg(`ESR_OFF_ENGINE, 32'h00000001);
    settle;
    stat;
    info(8'h7A, 1);
    chk("erase run", 0, eraseRun);
    test_done;
  end
endmodule
`default_nettype wire
